// file: rxd_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxd_regs.svh"

module rxd_chan #(
  parameter int OVR_DLY = `RXD_OVR_DELAY
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic [13:0]           i_sample,
  input  wire logic                  i_ovr,
  input  wire rxd_pkg::rxd_chan_cfg_t i_cfg,
  output var  rxd_pkg::rxd_chan_out_t o_out
);

  logic [OVR_DLY-1:0] ovr_q;
  logic signed [13:0] s1_q;
  logic [14:0]        mag_q;
  logic               above_q;
  logic               below_q;
  logic               flag_q;
  logic               flag_d;
  logic [15:0]        cnt_q;
  logic [15:0]        cnt_d;
  logic signed [43:0] acc_q;
  logic [15:0]        dc_q;
  logic [15:0]        data_q;

  //------------------------------------------------------------
  // magnitude and thresholds
  //------------------------------------------------------------
  // sign dropped, -8192 folds to full scale 2^13
  wire [14:0] mag = s1_q[13] ? 15'(-s1_q) : 15'(s1_q);
  wire [15:0] dwell_eff = (i_cfg.dwell == 16'h0000) ? 16'h0001
                                                    : i_cfg.dwell;
  wire        dwell_done = (cnt_q + 16'h0001) >= dwell_eff;

  // flag: set above upper, clear after a full dwell below lower, or at once when fd_en is off
  always_comb begin
    flag_d = flag_q;
    cnt_d  = 16'h0000;
    if (!i_cfg.fd_en) begin
      flag_d = 1'b0;
    end else if (above_q) begin
      flag_d = 1'b1;
    end else if (flag_q && below_q) begin
      if (dwell_done) begin
        flag_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  //------------------------------------------------------------
  // dc loop
  //------------------------------------------------------------
  wire [3:0] k_eff = (i_cfg.bw_k > `RXD_DC_K_MAX) ? `RXD_DC_K_MAX
                                                  : i_cfg.bw_k;
  wire signed [15:0] x16  = {s1_q, 2'b00};
  wire signed [16:0] err  = 17'(x16) - 17'($signed(dc_q));
  wire signed [43:0] step = 44'(err) <<< (`RXD_DC_K_BASE - k_eff);
  wire signed [16:0] corr = 17'(x16) - 17'($signed(dc_q));
  // saturate rather than wrap so a large offset cannot flip sign
  wire [15:0] corr_sat = (corr[16] != corr[15])
                       ? {corr[16], {15{~corr[16]}}} : corr[15:0];

  // four-stage detect pipe: sample, magnitude, compare, flag
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ovr_q   <= '0;
      s1_q    <= '0;
      mag_q   <= '0;
      above_q <= 1'b0;
      below_q <= 1'b0;
      flag_q  <= 1'b0;
      cnt_q   <= '0;
      acc_q   <= '0;
      dc_q    <= '0;
      data_q  <= '0;
    end else begin
      ovr_q   <= {ovr_q[OVR_DLY-2:0], i_ovr};
      s1_q    <= i_sample;
      mag_q   <= mag;
      above_q <= mag_q > i_cfg.upper;
      below_q <= mag_q < i_cfg.lower;
      flag_q  <= flag_d;
      cnt_q   <= cnt_d;
      if (!i_cfg.freeze) begin
        acc_q <= acc_q + step;
        dc_q  <= acc_q[`RXD_DC_FRAC+15:`RXD_DC_FRAC];
      end
      data_q  <= i_cfg.dc_en ? corr_sat : x16;
    end
  end

  assign o_out.data      = data_q;
  assign o_out.dc        = dc_q;
  assign o_out.near_clip = flag_q;
  assign o_out.ovr       = ovr_q[OVR_DLY-1];

endmodule
`default_nettype wire

// file: rxd_host.sv
`timescale 1ns/1ps
`default_nettype none
module rxd_host (
  input  wire logic i_ref_clk,
  input  wire logic i_go,
  output logic      o_align_strobe
);
  logic [1:0] cnt_q = 2'h0;

  // three-cycle strobe launched off the falling edge, clean when sampled
  always_ff @(negedge i_ref_clk) begin
    if (i_go) cnt_q <= 2'h3;
    else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
  end
  assign o_align_strobe = cnt_q != 2'h0;
endmodule
`default_nettype wire

// file: rxd_pkg.sv
package rxd_pkg;

  // per-channel settings handed to each channel slice
  typedef struct packed {
    logic [3:0]  bw_k;
    logic        freeze;
    logic        dc_en;
    logic        fd_en;
    logic [14:0] upper;
    logic [14:0] lower;
    logic [15:0] dwell;
  } rxd_chan_cfg_t;

  // per-channel results
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] dc;
    logic        near_clip;
    logic        ovr;
  } rxd_chan_out_t;

  // alignment field index inside the alignment register
  typedef enum logic [1:0] {
    RXD_AL_TUNER,
    RXD_AL_DIV,
    RXD_AL_FILT,
    RXD_AL_OUT
  } rxd_align_fld_t;

endpackage

// file: rxd_props.sv
`timescale 1ns/1ps
`default_nettype none
module rxd_props #(
  parameter int FPW = 2
) (
  input wire logic           i_ref_clk,
  input wire logic           i_reset,
  input wire logic           i_reg_wr,
  input wire logic [7:0]     i_reg_addr,
  input wire logic [7:0]     i_reg_wdata,
  input wire logic           i_align_strobe,
  input wire logic [13:0]    i_adc_a,
  input wire logic           i_ovr_a,
  input wire logic [31:0]    i_tuner_poff,
  input wire logic [FPW-1:0] i_filt_phase0,
  input wire logic           o_near_clip_flag_a,
  input wire logic           o_ovr_a,
  input wire logic [31:0]    o_phase_accum_tuner,
  input wire logic [FPW-1:0] o_filt_phase,
  input wire logic           o_low_latency_mode,
  input wire logic [3:0]     o_align_hit
);
  //------------------------------------------------------------
  // register shadow
  //------------------------------------------------------------
  logic [7:0]  sh_q [8'h40:8'h5F];
  logic        used_q;
  logic [3:0]  age_q;
  wire  [7:0]  al    = sh_q[8'h58];
  wire  [7:0]  sens  = sh_q[8'h59];
  wire  [14:0] up    = {sh_q[8'h48][6:0], sh_q[8'h47]};
  wire         wr_al = i_reg_wr && i_reg_addr == 8'h58;

  // only the digital control range is mirrored, writes land like the dut
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int k = 8'h40; k <= 8'h5F; k++)
        sh_q[k] <= (k == 8'h50) ? 8'hB0 : 8'h00;
    end else if (i_reg_wr && i_reg_addr[7:5] == 3'h2) begin
      sh_q[i_reg_addr] <= i_reg_wdata;
    end
  end

  // age guards $past against pre-reset history; a rewrite re-arms
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      used_q <= 1'b0;
      age_q  <= 4'h0;
    end else begin
      if (age_q != 4'hF) age_q <= age_q + 4'h1;
      if (wr_al) used_q <= 1'b0;
      else if (o_align_hit[0] && al[1]) used_q <= 1'b1;
    end
  end

  function automatic logic [14:0] mag(input logic [13:0] s);
    return s[13] ? {1'b0, -s} : {1'b0, s};
  endfunction

  //------------------------------------------------------------
  // properties
  //------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  property p_ovr;
    age_q > 4'h8 |-> o_ovr_a == $past(i_ovr_a, 7);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrange delay");
  property p_rise;
    $rose(o_near_clip_flag_a) && age_q > 4'h6
      |-> sh_q[8'h45][0] && mag($past(i_adc_a, 4)) > up;
  endproperty
  a_rise: assert property (p_rise) else $error("flag rose");
  property p_mode;
    o_low_latency_mode == (sh_q[8'h50] == 8'hB0);
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag");
  property p_en;
    (o_align_hit & ~{al[6], al[4], al[2], al[0]}) == 4'h0;
  endproperty
  a_en: assert property (p_en) else $error("hit while off");
  property p_edge;
    sens[1] && (o_align_hit[0] || o_align_hit[2])
      |-> $past(i_align_strobe, 2) == sens[0]
          && $past(i_align_strobe, 3) != sens[0];
  endproperty
  a_edge: assert property (p_edge) else $error("edge hit");
  property p_once;
    used_q |-> !o_align_hit[0];
  endproperty
  a_once: assert property (p_once) else $error("second hit");
  property p_tune;
    o_align_hit[0] |=> o_phase_accum_tuner == $past(i_tuner_poff);
  endproperty
  a_tune: assert property (p_tune) else $error("tuner load");
  property p_filt;
    o_align_hit[2] |=> o_filt_phase == $past(i_filt_phase0);
  endproperty
  a_filt: assert property (p_filt) else $error("filter load");

  c_hit: cover property (o_align_hit[0]);
  c_clip: cover property ($rose(o_near_clip_flag_a));
  c_ovr: cover property ($rose(o_ovr_a));
endmodule

bind rxd_top rxd_props #(.FPW(FPW)) u_props (
  .i_ref_clk, .i_reset, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
  .i_align_strobe, .i_adc_a, .i_ovr_a, .i_tuner_poff, .i_filt_phase0,
  .o_near_clip_flag_a, .o_ovr_a, .o_phase_accum_tuner, .o_filt_phase,
  .o_low_latency_mode, .o_align_hit
);
`default_nettype wire

// file: rxd_regs.svh
// What this block does
// - align strobe restarts filter at programmed phase
// - 0xB0 in filter mode register selects low-latency
// - 0xA0 in filter mode register selects high-performance
// - output translator shifts baseband to quarter rate
// - bits 7:6 align output translator, every or first
// - threshold select bit; flag low below threshold
// - compare magnitude only, sign ignored
// - overrange flag follows input seven cycles later
// - near-clip flag above upper threshold, four cycles
// - thresholds are magnitudes against 2^13 full scale
// - flag clears after dwell time below lower threshold
// - dwell time 1 to 65535 sample clocks
// - dc loop bandwidth k, 14 and 15 act as 13
// - dc correction value readable, 16 bits per channel
// - freeze holds dc value; clearing resumes estimate
// - enable bit inserts dc subtraction in data path
// - divider, tuner, filter, translator align independently
// - align strobe synchronised before use
// - level/edge and polarity for tuner, filters, translators only
// - bits 1:0 align tuner to its phase offset
`ifndef RXD_REGS_SVH
`define RXD_REGS_SVH

//--------------------------------------------------------------
// register offsets
//--------------------------------------------------------------
`define RXD_A_DC_CTRL     8'h40
`define RXD_A_DC_LO       8'h41
`define RXD_A_DC_HI       8'h42
`define RXD_A_FD_SEL      8'h45
`define RXD_A_UP_LO       8'h47
`define RXD_A_UP_HI       8'h48
`define RXD_A_LOW_LO      8'h49
`define RXD_A_LOW_HI      8'h4A
`define RXD_A_DWELL_LO    8'h4B
`define RXD_A_DWELL_HI    8'h4C
`define RXD_A_FILT_MODE   8'h50
`define RXD_A_ALIGN       8'h58
`define RXD_A_ALIGN_SENS  8'h59
`define RXD_A_XLAT_SEL    8'h5A

//--------------------------------------------------------------
// field positions and values
//--------------------------------------------------------------
`define RXD_B_DC_EN       1
`define RXD_B_DC_K_LSB    2
`define RXD_B_DC_K_MSB    5
`define RXD_B_DC_FREEZE   6
`define RXD_B_FD_SEL      0
`define RXD_B_SENS_EDGE   1
`define RXD_B_SENS_RISE   0
`define RXD_B_XLAT_FIXED  0
`define RXD_MODE_LOW_LAT  8'hB0
`define RXD_MODE_HIGH_PERF 8'hA0
`define RXD_DC_K_MAX      4'hD
`define RXD_DC_K_BASE     4'hD
`define RXD_DC_FRAC       27

//--------------------------------------------------------------
// reset values and latencies
//--------------------------------------------------------------
`define RXD_RST_REG       8'h00
`define RXD_RST_FILT_MODE 8'hB0
`define RXD_OVR_DELAY     7
`define RXD_FD_LATENCY    4

`endif

// file: rxd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxd_regs.svh"

module rxd_top #(
  parameter int FPW     = 2,
  parameter int DIV_MAX = 8
) (
  input  wire logic           i_ref_clk,
  input  wire logic           i_reset,
  // register port, one byte per access
  input  wire logic           i_reg_wr,
  input  wire logic [7:0]     i_reg_addr,
  input  wire logic [7:0]     i_reg_wdata,
  input  wire logic           i_reg_chan,
  output logic      [7:0]     o_reg_rdata,
  // align strobe pin, asynchronous
  input  wire logic           i_align_strobe,
  // converter samples and overrange, sample clock domain
  input  wire logic [13:0]    i_adc_a,
  input  wire logic [13:0]    i_adc_b,
  input  wire logic           i_ovr_a,
  input  wire logic           i_ovr_b,
  // tuner programming and filter phase from outside
  input  wire logic [31:0]    i_tuner_fword,
  input  wire logic [31:0]    i_tuner_poff,
  input  wire logic [FPW-1:0] i_filt_phase0,
  input  wire logic [7:0]     i_div_ratio,
  // filtered complex baseband
  input  wire logic [15:0]    i_bb_i,
  input  wire logic [15:0]    i_bb_q,
  output logic      [15:0]    o_data_a,
  output logic      [15:0]    o_data_b,
  output logic                o_near_clip_flag_a,
  output logic                o_near_clip_flag_b,
  output logic                o_ovr_a,
  output logic                o_ovr_b,
  output logic      [31:0]    o_phase_accum_tuner,
  output logic      [FPW-1:0] o_filt_phase,
  output logic      [7:0]     o_div_phase,
  output logic      [15:0]    o_real_out,
  output logic                o_low_latency_mode,
  output logic                o_fixed_translator,
  output logic      [3:0]     o_align_hit
);

  //------------------------------------------------------------
  // register storage
  //------------------------------------------------------------
  logic [7:0] dc_ctrl_q;
  logic [7:0] fd_sel_q;
  logic [7:0] up_lo_q;
  logic [7:0] up_hi_q;
  logic [7:0] low_lo_q;
  logic [7:0] low_hi_q;
  logic [7:0] dwell_lo_q;
  logic [7:0] dwell_hi_q;
  logic [7:0] filt_mode_q;
  logic [7:0] align_q;
  logic [7:0] sens_q;
  logic [7:0] xlat_q;
  logic [7:0] rdata_q;

  //------------------------------------------------------------
  // write decode
  //------------------------------------------------------------
  wire wr_dc_ctrl  = i_reg_wr && (i_reg_addr == `RXD_A_DC_CTRL);
  wire wr_fd_sel   = i_reg_wr && (i_reg_addr == `RXD_A_FD_SEL);
  wire wr_up_lo    = i_reg_wr && (i_reg_addr == `RXD_A_UP_LO);
  wire wr_up_hi    = i_reg_wr && (i_reg_addr == `RXD_A_UP_HI);
  wire wr_low_lo   = i_reg_wr && (i_reg_addr == `RXD_A_LOW_LO);
  wire wr_low_hi   = i_reg_wr && (i_reg_addr == `RXD_A_LOW_HI);
  wire wr_dwell_lo = i_reg_wr && (i_reg_addr == `RXD_A_DWELL_LO);
  wire wr_dwell_hi = i_reg_wr && (i_reg_addr == `RXD_A_DWELL_HI);
  wire wr_mode     = i_reg_wr && (i_reg_addr == `RXD_A_FILT_MODE);
  wire wr_align    = i_reg_wr && (i_reg_addr == `RXD_A_ALIGN);
  wire wr_sens     = i_reg_wr && (i_reg_addr == `RXD_A_ALIGN_SENS);
  wire wr_xlat     = i_reg_wr && (i_reg_addr == `RXD_A_XLAT_SEL);

  // settings are shared by both channels; writes land in one edge
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dc_ctrl_q   <= `RXD_RST_REG;
      fd_sel_q    <= `RXD_RST_REG;
      up_lo_q     <= `RXD_RST_REG;
      up_hi_q     <= `RXD_RST_REG;
      low_lo_q    <= `RXD_RST_REG;
      low_hi_q    <= `RXD_RST_REG;
      dwell_lo_q  <= `RXD_RST_REG;
      dwell_hi_q  <= `RXD_RST_REG;
      filt_mode_q <= `RXD_RST_FILT_MODE;
      align_q     <= `RXD_RST_REG;
      sens_q      <= `RXD_RST_REG;
      xlat_q      <= `RXD_RST_REG;
    end else begin
      if (wr_dc_ctrl)  dc_ctrl_q   <= i_reg_wdata;
      if (wr_fd_sel)   fd_sel_q    <= i_reg_wdata;
      if (wr_up_lo)    up_lo_q     <= i_reg_wdata;
      if (wr_up_hi)    up_hi_q     <= i_reg_wdata;
      if (wr_low_lo)   low_lo_q    <= i_reg_wdata;
      if (wr_low_hi)   low_hi_q    <= i_reg_wdata;
      if (wr_dwell_lo) dwell_lo_q  <= i_reg_wdata;
      if (wr_dwell_hi) dwell_hi_q  <= i_reg_wdata;
      if (wr_mode)     filt_mode_q <= i_reg_wdata;
      if (wr_align)    align_q     <= i_reg_wdata;
      if (wr_sens)     sens_q      <= i_reg_wdata;
      if (wr_xlat)     xlat_q      <= i_reg_wdata;
    end
  end

  //------------------------------------------------------------
  // channel slices
  //------------------------------------------------------------
  rxd_pkg::rxd_chan_cfg_t cfg;
  rxd_pkg::rxd_chan_out_t out_a;
  rxd_pkg::rxd_chan_out_t out_b;

  // the high byte carries bits 14:8; bit 7 of it is reserved
  assign cfg.bw_k   = dc_ctrl_q[`RXD_B_DC_K_MSB:`RXD_B_DC_K_LSB];
  assign cfg.freeze = dc_ctrl_q[`RXD_B_DC_FREEZE];
  assign cfg.dc_en  = dc_ctrl_q[`RXD_B_DC_EN];
  assign cfg.fd_en  = fd_sel_q[`RXD_B_FD_SEL];
  assign cfg.upper  = {up_hi_q[6:0], up_lo_q};
  assign cfg.lower  = {low_hi_q[6:0], low_lo_q};
  assign cfg.dwell  = {dwell_hi_q, dwell_lo_q};

  rxd_chan u_chan_a (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_sample  (i_adc_a),
    .i_ovr     (i_ovr_a),
    .i_cfg     (cfg),
    .o_out     (out_a)
  );

  rxd_chan u_chan_b (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_sample  (i_adc_b),
    .i_ovr     (i_ovr_b),
    .i_cfg     (cfg),
    .o_out     (out_b)
  );

  assign o_data_a           = out_a.data;
  assign o_data_b           = out_b.data;
  assign o_near_clip_flag_a = out_a.near_clip;
  assign o_near_clip_flag_b = out_b.near_clip;
  assign o_ovr_a            = out_a.ovr;
  assign o_ovr_b            = out_b.ovr;

  //------------------------------------------------------------
  // readback
  //------------------------------------------------------------
  // the channel select picks which dc estimate is shown
  wire [15:0] dc_sel = i_reg_chan ? out_b.dc : out_a.dc;
  logic [7:0] rd_mux;

  always_comb begin
    case (i_reg_addr)
      `RXD_A_DC_CTRL:    rd_mux = dc_ctrl_q;
      `RXD_A_DC_LO:      rd_mux = dc_sel[7:0];
      `RXD_A_DC_HI:      rd_mux = dc_sel[15:8];
      `RXD_A_FD_SEL:     rd_mux = fd_sel_q;
      `RXD_A_UP_LO:      rd_mux = up_lo_q;
      `RXD_A_UP_HI:      rd_mux = up_hi_q;
      `RXD_A_LOW_LO:     rd_mux = low_lo_q;
      `RXD_A_LOW_HI:     rd_mux = low_hi_q;
      `RXD_A_DWELL_LO:   rd_mux = dwell_lo_q;
      `RXD_A_DWELL_HI:   rd_mux = dwell_hi_q;
      `RXD_A_FILT_MODE:  rd_mux = filt_mode_q;
      `RXD_A_ALIGN:      rd_mux = align_q;
      `RXD_A_ALIGN_SENS: rd_mux = sens_q;
      `RXD_A_XLAT_SEL:   rd_mux = xlat_q;
      default:           rd_mux = 8'h00;
    endcase
  end

  // registered so the port never shows a mid-decode glitch
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign o_reg_rdata = rdata_q;

  //------------------------------------------------------------
  // filter mode
  //------------------------------------------------------------
  // other codes flag neither mode and hold the real output at zero
  assign o_low_latency_mode = (filt_mode_q == `RXD_MODE_LOW_LAT);
  wire   high_perf          = (filt_mode_q == `RXD_MODE_HIGH_PERF);
  // the host must also park the tuner at quarter rate
  assign o_fixed_translator = xlat_q[`RXD_B_XLAT_FIXED];

  //------------------------------------------------------------
  // align strobe synchroniser and detection
  //------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;

  // the pin is asynchronous; only sync2 and sync3 are looked at by logic
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= i_align_strobe;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire rise     = sync2_q & ~sync3_q;
  wire fall     = ~sync2_q & sync3_q;
  wire edge_sel = sens_q[`RXD_B_SENS_RISE] ? rise : fall;
  // level mode restarts on every cycle the strobe is held high
  wire trig_dsp = sens_q[`RXD_B_SENS_EDGE] ? edge_sel : sync2_q;
  // the divider ignores the sensitivity setting
  wire trig_div = rise;

  //------------------------------------------------------------
  // per-block alignment arms
  //------------------------------------------------------------
  logic [3:0] arm_q;
  logic [3:0] arm_d;
  logic [3:0] hit;
  logic [3:0] trig;

  assign trig[rxd_pkg::RXD_AL_TUNER] = trig_dsp;
  assign trig[rxd_pkg::RXD_AL_DIV]   = trig_div;
  assign trig[rxd_pkg::RXD_AL_FILT]  = trig_dsp;
  assign trig[rxd_pkg::RXD_AL_OUT]   = trig_dsp;

  // even bit enables, odd bit limits to the first strobe
  for (genvar f = 0; f < 4; f++) begin : g_align
    wire en    = align_q[2*f];
    wire first = align_q[2*f+1];
    assign hit[f] = trig[f] & en & (~first | arm_q[f]);
    // a write re-arms and wins over a first-only arm being consumed
    assign arm_d[f] = wr_align | (arm_q[f] & ~(hit[f] & first));
  end

  // one process owns all four arms
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      arm_q <= 4'h0;
    end else begin
      arm_q <= arm_d;
    end
  end

  assign o_align_hit = hit;

  //------------------------------------------------------------
  // clock divider phase
  //------------------------------------------------------------
  logic [7:0] div_q;
  wire  [7:0] div_last = (i_div_ratio == 8'h00) ? 8'h00
                                                : i_div_ratio - 8'h01;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      div_q <= 8'h00;
    end else if (hit[rxd_pkg::RXD_AL_DIV]) begin
      div_q <= 8'h00;
    end else if (div_q >= div_last) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign o_div_phase = div_q;

  //------------------------------------------------------------
  // tuner phase accumulator
  //------------------------------------------------------------
  logic [31:0] tun_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      tun_q <= 32'h0000_0000;
    end else if (hit[rxd_pkg::RXD_AL_TUNER]) begin
      tun_q <= i_tuner_poff;
    end else begin
      tun_q <= tun_q + i_tuner_fword;
    end
  end

  assign o_phase_accum_tuner = tun_q;

  //------------------------------------------------------------
  // filter phase
  //------------------------------------------------------------
  // no decimation, so the phase only marks the tap alignment
  logic [FPW-1:0] fph_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fph_q <= '0;
    end else if (hit[rxd_pkg::RXD_AL_FILT]) begin
      fph_q <= i_filt_phase0;
    end else begin
      fph_q <= fph_q + FPW'(1);
    end
  end

  assign o_filt_phase = fph_q;

  //------------------------------------------------------------
  // quarter-rate output translator
  //------------------------------------------------------------
  logic [1:0]  rot_q;
  logic [15:0] real_q;
  logic [15:0] real_d;

  // negate with clamp so -32768 does not wrap to itself
  function automatic logic [15:0] neg_sat(input logic [15:0] v);
    logic [15:0] r;
    r = (v == 16'h8000) ? 16'h7FFF : 16'(-v);
    return r;
  endfunction

  // i, -q, -i, q keeps the real part of a quarter-rate spin
  always_comb begin
    case (rot_q)
      2'h0:    real_d = i_bb_i;
      2'h1:    real_d = neg_sat(i_bb_q);
      2'h2:    real_d = neg_sat(i_bb_i);
      2'h3:    real_d = i_bb_q;
      default: real_d = i_bb_i;
    endcase
  end

  // both filter modes run at the sample rate, so one word a clock
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rot_q  <= 2'h0;
      real_q <= 16'h0000;
    end else begin
      real_q <= (o_low_latency_mode || high_perf) ? real_d : 16'h0000;
      if (hit[rxd_pkg::RXD_AL_OUT]) begin
        rot_q <= 2'h0;
      end else begin
        rot_q <= rot_q + 2'h1;
      end
    end
  end

  assign o_real_out = real_q;

endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, go = 1'b0, ovr = 1'b0;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rd, dph;
  logic [13:0] adc = 14'h0000;
  logic [15:0] bbi = 16'h0000, bbq = 16'h0000, da, db, ro, r [4];
  logic [31:0] poff = 32'h0000_0000, tun;
  logic [1:0]  fph;
  logic [3:0]  hit;
  logic        fa, fb, oa, ob, llm, fxt, strobe;
  int          miscompares = 0, checks = 0, cyc = 0;
  // rows: address, write byte, expected read
  logic [23:0] rows [12] = '{24'h45_01_01, 24'h47_58_58, 24'h48_1B_1B,
    24'h49_00_00, 24'h4A_10_10, 24'h4B_03_03, 24'h4C_00_00,
    24'h59_03_03, 24'h5A_01_01, 24'h40_3C_3C,
    24'h41_FF_00, 24'h43_A5_00};

  //------------------------------------------------------------
  // design and partner
  //------------------------------------------------------------
  rxd_top #(.FPW(2)) dut (.i_ref_clk(clk), .i_reset(rst),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_chan(1'b0), .o_reg_rdata(rd), .i_align_strobe(strobe),
    .i_adc_a(adc), .i_adc_b(adc), .i_ovr_a(ovr), .i_ovr_b(ovr),
    .i_tuner_fword(32'h0000_0000), .i_tuner_poff(poff),
    .i_filt_phase0(2'h2), .i_div_ratio(8'h00), .i_bb_i(bbi),
    .i_bb_q(bbq), .o_data_a(da), .o_data_b(db),
    .o_near_clip_flag_a(fa), .o_near_clip_flag_b(fb), .o_ovr_a(oa),
    .o_ovr_b(ob), .o_phase_accum_tuner(tun), .o_filt_phase(fph),
    .o_div_phase(dph), .o_real_out(ro), .o_low_latency_mode(llm),
    .o_fixed_translator(fxt), .o_align_hit(hit));
  rxd_host host (.i_ref_clk(clk), .i_go(go), .o_align_strobe(strobe));

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    addr = a;
    wd = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    addr = a;
    tick(1);
    chk({24'h0, rd}, {24'h0, e});
  endtask
  // strobe through the partner, then check where the tuner restarted
  task automatic algn(input logic [31:0] p, e);
    poff = p;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(10);
    chk(tun, e);
  endtask

  // free-running clock and hang guard
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    tick(3);
    rst = 1'b0;
    rd_chk(8'h50, 8'hB0);
    chk1(llm, 1'b1);
    wr_reg(8'h50, 8'hA0);
    chk1(llm, 1'b0);
    wr_reg(8'h50, 8'hB0);
    foreach (rows[n]) begin
      wr_reg(rows[n][23:16], rows[n][15:8]);
      rd_chk(rows[n][23:16], rows[n][7:0]);
    end
    chk1(fxt, 1'b1);
    // both signs of the same magnitude must behave alike
    for (int s = 0; s < 2; s++) begin
      adc = s ? 14'h1F40 : 14'h20C0;
      tick(2);
      chk1(fa, 1'b0);
      tick(4);
      chk1(fa, 1'b1);
      chk1(fb, 1'b1);
      adc = 14'h0000;
      tick(2);
      chk1(fa, 1'b1);
      tick(12);
      chk1(fa, 1'b0);
    end
    // detection switched off holds the flag low
    wr_reg(8'h45, 8'h00);
    adc = 14'h20C0;
    tick(8);
    chk1(fa, 1'b0);
    adc = 14'h0123;
    wr_reg(8'h45, 8'h01);
    tick(4);
    chk({16'h0, da}, 32'h0000_048C);
    chk({16'h0, db}, 32'h0000_048C);
    adc = 14'h0000;
    ovr = 1'b1;
    tick(1);
    ovr = 1'b0;
    tick(5);
    chk1(oa, 1'b0);
    tick(1);
    chk1(oa, 1'b1);
    chk1(ob, 1'b1);
    // constant i and q must give i, -q, -i, q in some rotation
    bbi = 16'h0100;
    bbq = 16'h0040;
    tick(6);
    for (int k = 0; k < 4; k++) begin
      r[k] = ro;
      tick(1);
    end
    chk({16'h0, r[0] + r[2]}, 32'h0);
    chk({16'h0, r[1] + r[3]}, 32'h0);
    chk1(r[0] == r[1], 1'b0);
    // tuner, filter and output translator all restart on one strobe
    wr_reg(8'h58, 8'h51);
    algn(32'hA5A5_0001, 32'hA5A5_0001);
    chk({30'h0, fph}, 32'h0000_0001);
    chk({16'h0, ro}, 32'h0000_FF00);
    wr_reg(8'h58, 8'h03);
    algn(32'hA5A5_0002, 32'hA5A5_0002);
    algn(32'hA5A5_0003, 32'hA5A5_0002);
    wr_reg(8'h58, 8'h03);
    algn(32'hA5A5_0004, 32'hA5A5_0004);
    wr_reg(8'h59, 8'h02);
    wr_reg(8'h58, 8'h51);
    algn(32'hA5A5_0005, 32'hA5A5_0005);
    chk({30'h0, fph}, 32'h0000_0002);
    chk({16'h0, ro}, 32'h0000_0040);
    // level mode restarts on every high cycle, so the last one counts
    wr_reg(8'h59, 8'h00);
    algn(32'hA5A5_0006, 32'hA5A5_0006);
    chk({30'h0, fph}, 32'h0000_0003);
    chk({16'h0, ro}, 32'h0000_0100);
    chk({24'h0, dph}, 32'h0000_0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
